/* testbench/encoder_far_side.sv */
// local bus responder standing behind the host port
`timescale 1ns/100ps
// =====================================================
// model of the local bus slave
module encoder_far_side (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // local bus
    input  wire logic        lbReq,
    input  wire logic        lbWrite,
    input  wire logic [18:0] lbAddr,
    input  wire logic [31:0] lbWdata,
    output logic             lbAck,
    output logic      [31:0] lbRdata,
    // bench view
    input  wire logic [3:0]  waitCycles,
    output logic      [31:0] lastWrite
);
    logic [3:0] cnt;
    // answer after waitCycles; read data toggles when not acked so stale values never pass
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            lbAck <= 1'b0;
            lbRdata <= 32'h0;
            lastWrite <= 32'h0;
        end else begin
            lbAck <= 1'b0;
            lbRdata <= ~lbRdata;
            if (lbReq && !lbAck) begin
                cnt <= cnt + 4'h1;
                if (cnt == waitCycles) begin
                    cnt <= 4'h0;
                    lbAck <= 1'b1;
                    lbRdata <= {13'h0a5, lbAddr};
                    if (lbWrite) lastWrite <= lbWdata;
                end
            end
        end
    end
endmodule

/* testbench/multiproc_encoder_host_port_bench.sv */
// self-checking bench of the encoder host port
`timescale 1ns/100ps
`include "host_port_defines.svh"
`define CHK(n,e,g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module multiproc_encoder_host_port_bench;
    import host_port_pkg::*;
    // =====================================================
    // signals
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
    logic frameSyncPin = 0, lineSyncPin = 0, encodeRun = 0, codeValid = 0, codeReady, sliceDone = 0;
    logic lbReq, lbWrite, lbAck, procWrite = 0, irq;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat, lbWdata, lbRdata, procData = 0, lastWrite, seed = 32'h77d4, a;
    logic [3:0] pstrb = 4'hf, waitCycles = 0;
    logic [9:0] outGrant, captureSel;
    logic [18:0] lbAddr;
    stageVec_type stageActive, stageStart;
    int failures = 0, checks_done = 0, n;
    encoder_host_port #(.CODE_WORDS(16)) i_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .frameSyncPin, .lineSyncPin, .encodeRun, .codeValid, .codeReady,
        .sliceDone, .outGrant, .captureSel, .stageActive, .stageStart, .lbReq, .lbWrite, .lbAddr,
        .lbWdata, .lbAck, .lbRdata, .procWrite, .procData, .irq);
    encoder_far_side i_far (.clock, .rst, .lbReq, .lbWrite, .lbAddr, .lbWdata, .lbAck, .lbRdata,
        .waitCycles, .lastWrite);
    // free running 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end
    // =====================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic stageVec_type stages(input int k);
        return (k >= 5) ? 5'h1f : stageVec_type'((1 << k) - 1);
    endfunction
    // processor owning the next line once j lines of l are in, s slices shared evenly
    function automatic logic [9:0] sliceOf(input int j, input int s, input int l);
        return (j < l) ? 10'(1 << (j * s / l)) : 10'h000;
    endfunction
    task automatic give_verdict();
        if (failures == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        @(posedge clock) begin psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d; end
        @(posedge clock) penable <= 1;
        k = 0;
        do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 200);
        if (k >= 200) begin failures++; give_verdict(); end
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic push(input int k);
        repeat (k) @(posedge clock) codeValid <= 1;
        @(posedge clock) codeValid <= 0;
    endtask
    task automatic tick(input stageVec_type e);
        @(posedge clock) frameSyncPin <= 1;
        repeat (2) @(posedge clock);
        frameSyncPin <= 0;
        repeat (2) @(posedge clock);
        `CHK("start", e, stageStart)
        repeat (6) @(posedge clock);
    endtask
    // one line start pulse from the video source
    task automatic scanLine();
        @(posedge clock) lineSyncPin <= 1;
        @(posedge clock) lineSyncPin <= 0;
        repeat (3) @(posedge clock);
    endtask
    // =====================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 0;
        apb(0, `OFF_METER, 0); `CHK("meter", 32'h0, rdat)
        apb(0, 8'h1c, 0); `CHK("unmapped", 1'b1, rerr)
        apb(0, 8'h02, 0); `CHK("unaligned", 1'b1, rerr)
        seed = lfsr(seed);
        n = 1 + seed[3:0] % 15;
        push(n);
        apb(0, `OFF_METER, 0); `CHK("meter fill", 32'(n), rdat)
        apb(1, `OFF_ADDR, 32'h80000);
        apb(0, `OFF_DATA, 0);
        apb(0, `OFF_METER, 0); `CHK("meter pop", 32'(n - 1), rdat)
        push(20);
        apb(0, `OFF_METER, 0); `CHK("meter full", 32'd16, rdat)
        `CHK("ready", 1'b0, codeReady)
        apb(0, `OFF_IRQ_STATUS, 0); `CHK("full evt", 1'b1, rdat[`IRQ_FULL])
        `CHK("masked", 1'b0, irq)
        apb(1, `OFF_IRQ_ENABLE, 32'h4);
        repeat (2) @(posedge clock); `CHK("irq on", 1'b1, irq)
        apb(1, `OFF_IRQ_CLEAR, 32'hf);
        repeat (2) @(posedge clock); `CHK("irq off", 1'b0, irq)
        // local bus writes and reads, prompt and slow partner
        for (int i = 0; i < 2; i++) begin
            waitCycles <= 4'(i * 5);
            seed = lfsr(seed);
            a = {13'h0, seed[18:0]};
            apb(1, `OFF_ADDR, a);
            seed = lfsr(seed);
            apb(1, `OFF_DATA, seed); `CHK("lb write", seed, lastWrite)
            apb(0, `OFF_DATA, 0); `CHK("lb read", {13'h0a5, a[18:0]}, rdat)
        end
        @(posedge clock) begin procWrite <= 1; procData <= seed; end
        @(posedge clock) procWrite <= 0;
        apb(1, `OFF_ADDR, 32'h100000);
        pstrb <= 4'h2;
        apb(1, `OFF_ADDR, 32'hffffffff);
        pstrb <= 4'hf;
        apb(0, `OFF_ADDR, 0); `CHK("strobe", 32'h0010ff00, rdat)
        apb(0, `OFF_DATA, 0); `CHK("mailbox", seed, rdat)
        apb(1, `OFF_SCV, 32'hab000000);
        apb(0, `OFF_SCV, 0); `CHK("vector", 8'hab, rdat[31:24])
        // frames through the five stages, then slice output in order
        encodeRun <= 1;
        for (int k = 1; k <= 5; k++) begin
            tick(stages(k)); `CHK("stages", stages(k), stageActive)
        end
        apb(0, `OFF_SCV, 0); `CHK("scv", 6'h3f, rdat[5:0])
        `CHK("grant", 10'h001, outGrant)
        for (int i = 1; i <= 9; i++) begin
            @(posedge clock) sliceDone <= 1;
            @(posedge clock) sliceDone <= 0;
            repeat (2) @(posedge clock);
            `CHK("grant", (i < 9) ? 10'(1 << i) : 10'h0, outGrant)
        end
        // every line of a frame goes to its slice's processor, both standards
        for (int p = 0; p < 2; p++) begin
            apb(1, `OFF_SCV, 32'(p) << 6);
            tick(5'h1f);
            for (int j = 0; j <= 480 + 96 * p; j++) begin
                `CHK("capture", sliceOf(j, 9 + p, 480 + 96 * p), captureSel)
                if (j < 480 + 96 * p) scanLine();
            end
        end
        encodeRun <= 0;
        tick(5'h1e); `CHK("stop", 5'h1e, stageActive)
        apb(0, `OFF_IRQ_STATUS, 0); `CHK("out done", 1'b1, rdat[`IRQ_OUTDONE])
        give_verdict();
    end
endmodule

/* verilog/encoder_host_port.sv */
// host port, frame pipeline sequencer and code buffer meter of the multiprocessor encoder
`timescale 1ns/100ps
`include "host_port_defines.svh"
// =====================================================================
// Behaviour
// [R1] five stages: capture, preprocess, motion, encode, output
// [R2] each stage one frame, all concurrent
// [R3] nine slices for 525, ten for 625
// [R4] each processor captures its slice, 480/576 lines
// [R5] capture runs in background of core work
// [R6] preprocess frame computes activity estimate
// [R7] third frame does motion search per macroblock
// [R8] fourth frame transforms, codes, stores result
// [R9] fifth frame outputs slices in processor order
// [R10] code buffer holds 1 Mbyte, host drains
// [R11] meter register always shows buffer fill
// [R12] host address register selects local location
// [R13] data register bridges host and local bus
// [R14] status/config/vector register readable by host
// [R15] host starts/stops via flag in memory
// [R16] host supplies start parameters before starting
// [R17] 2 Mbytes local memory, two 256Kx32 pages
// [R18] source delivers 708x480 samples on input bus
// [R19] meter rises on writes, falls on reads
module encoder_host_port #(
    parameter int MAX_PROC    = 10,
    parameter int NTSC_SLICES = 9,
    parameter int PAL_SLICES  = 10,
    parameter int NTSC_LINES  = 480,
    parameter int PAL_LINES   = 576,
    parameter int CODE_WORDS  = 262144,
    parameter int LB_AW       = 19
) (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // video input bus timing pins
    input  wire logic                      frameSyncPin,
    input  wire logic                      lineSyncPin,
    // master processor run flag
    input  wire logic                      encodeRun,
    // compressed output bus
    input  wire logic                      codeValid,
    output logic                           codeReady,
    input  wire logic                      sliceDone,
    output logic      [MAX_PROC-1:0]       outGrant,
    // pipeline control
    output logic      [MAX_PROC-1:0]       captureSel,
    output host_port_pkg::stageVec_type    stageActive,
    output host_port_pkg::stageVec_type    stageStart,
    // local bus
    output logic                           lbReq,
    output logic                           lbWrite,
    output logic      [LB_AW-1:0]          lbAddr,
    output logic      [31:0]               lbWdata,
    input  wire logic                      lbAck,
    input  wire logic [31:0]               lbRdata,
    // processor to host mailbox
    input  wire logic                      procWrite,
    input  wire logic [31:0]               procData,
    // interrupt
    output logic                           irq
);
    import host_port_pkg::*;

    localparam int MW = $clog2(CODE_WORDS + 1);

    // =====================================================================
    // parameter checks
    if (PAL_SLICES > MAX_PROC || NTSC_SLICES > MAX_PROC || MAX_PROC > 15 ||
        PAL_LINES > 1023 || NTSC_LINES > 1023 || LB_AW < 1 || LB_AW > `ADDR_CODE_POS) begin : badParams
        $error("encoder_host_port: parameter out of range");
    end

    // =====================================================================
    // helpers
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wr,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = wr[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [MAX_PROC-1:0] oneHot(input logic [3:0] idx, input logic en);
        logic [MAX_PROC-1:0] r;
        r = '0;
        if (en && idx < 4'(MAX_PROC)) begin
            r[idx] = 1'b1;
        end
        return r;
    endfunction

    // =====================================================================
    // state
    busState_type      busState_q, busState_d;
    logic              pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0]       prdata_q, prdata_d;
    logic              lbReq_q, lbReq_d, lbWrite_q, lbWrite_d;
    logic [LB_AW-1:0]  lbAddr_q, lbAddr_d;
    logic [31:0]       lbWdata_q, lbWdata_d;
    logic [31:0]       addr_q, addr_d, mailbox_q, mailbox_d;
    logic [7:0]        vector_q, vector_d;
    logic              pal_q, pal_d;
    irqVec_type        irqEn_q, irqEn_d, irqStat_q, irqStat_d;
    logic              irq_q, irq_d;
    logic [MW-1:0]     meter_q, meter_d;
    logic              codeReady_q, codeReady_d;
    logic [2:0]        fSync_q, fSync_d, lSync_q, lSync_d;
    stageVec_type      occ_q, occ_d, stageStart_q, stageStart_d;
    logic [9:0]        lineCount_q, lineCount_d, acc_q, acc_d;
    logic [3:0]        sliceIdx_q, sliceIdx_d, outIdx_q, outIdx_d;
    logic [MAX_PROC-1:0] captureSel_q, captureSel_d, outGrant_q, outGrant_d;
    logic              outBusy_q, outBusy_d;
    logic              frameTick, lineTick, outDoneEvt, popNow, pushNow, doWrite;
    logic [3:0]        slices;
    logic [9:0]        lines;
    logic [10:0]       sum;
    logic [31:0]       status_config_vector_reg;

    // =====================================================================
    // frame pipeline, capture slicing and ordered output
    always_comb begin
        slices       = pal_q ? 4'(PAL_SLICES) : 4'(NTSC_SLICES);   // see R3
        lines        = pal_q ? 10'(PAL_LINES) : 10'(NTSC_LINES);   // see R4
        fSync_d      = {fSync_q[1:0], frameSyncPin};
        lSync_d      = {lSync_q[1:0], lineSyncPin};
        frameTick    = fSync_q[1] & ~fSync_q[2];
        lineTick     = lSync_q[1] & ~lSync_q[2];
        // every frame tick advances each frame one stage; all five run at once
        occ_d        = frameTick ? {occ_q[3:0], encodeRun} : occ_q;   // see R1 R2
        // stage start pulses kick preprocess, motion search and coding programs
        stageStart_d = frameTick ? {occ_q[3:0], encodeRun} : 5'h00;   // see R6 R7 R8
        lineCount_d  = lineCount_q;
        acc_d        = acc_q;
        sliceIdx_d   = sliceIdx_q;
        sum          = 11'(acc_q) + 11'(slices);
        // slice boundaries by accumulator so 480/9 and 576/10 share lines evenly
        if (frameTick) begin
            lineCount_d = 10'h000;
            acc_d       = 10'h000;
            sliceIdx_d  = 4'h0;
        end else if (lineTick && lineCount_q < lines) begin   // see R4
            lineCount_d = lineCount_q + 10'h001;
            if (sum >= 11'(lines)) begin
                acc_d      = 10'(sum - 11'(lines));
                sliceIdx_d = sliceIdx_q + 4'h1;
            end else begin
                acc_d      = sum[9:0];
            end
        end
        // capture selection needs no core involvement, so it runs beside other stages
        captureSel_d = oneHot(sliceIdx_d, lineCount_d < lines && occ_d[`STAGE_CAPTURE]);   // see R5 R4
        outBusy_d    = outBusy_q;
        outIdx_d     = outIdx_q;
        outDoneEvt   = 1'b0;
        // output stage grants the output bus to processors strictly in slice order
        if (frameTick && occ_q[`STAGE_ENCODE]) begin   // see R9
            outBusy_d = 1'b1;
            outIdx_d  = 4'h0;
        end else if (outBusy_q && sliceDone) begin
            if (outIdx_q == slices - 4'h1) begin
                outBusy_d  = 1'b0;
                outDoneEvt = 1'b1;
            end else begin
                outIdx_d   = outIdx_q + 4'h1;
            end
        end
        outGrant_d = oneHot(outIdx_d, outBusy_d);   // see R9
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fSync_q      <= 3'h0;
            lSync_q      <= 3'h0;
            occ_q        <= 5'h00;
            stageStart_q <= 5'h00;
            lineCount_q  <= 10'h000;
            acc_q        <= 10'h000;
            sliceIdx_q   <= 4'h0;
            captureSel_q <= '0;
            outBusy_q    <= 1'b0;
            outIdx_q     <= 4'h0;
            outGrant_q   <= '0;
        end else begin
            fSync_q      <= fSync_d;
            lSync_q      <= lSync_d;
            occ_q        <= occ_d;
            stageStart_q <= stageStart_d;
            lineCount_q  <= lineCount_d;
            acc_q        <= acc_d;
            sliceIdx_q   <= sliceIdx_d;
            captureSel_q <= captureSel_d;
            outBusy_q    <= outBusy_d;
            outIdx_q     <= outIdx_d;
            outGrant_q   <= outGrant_d;
        end
    end

    // =====================================================================
    // apb transfer sequencing and local bus bridge
    always_comb begin
        busState_d = busState_q;
        pready_d   = 1'b0;
        pslverr_d  = pslverr_q;
        prdata_d   = prdata_q;
        lbReq_d    = lbReq_q;
        lbWrite_d  = lbWrite_q;
        lbAddr_d   = lbAddr_q;
        lbWdata_d  = lbWdata_q;
        status_config_vector_reg        = 32'h0000_0000;
        status_config_vector_reg[`SCV_RUN_POS]                 = encodeRun;
        status_config_vector_reg[`SCV_STAGE_LSB +: 5]          = occ_q;
        status_config_vector_reg[`SCV_PAL_POS]                 = pal_q;
        status_config_vector_reg[`SCV_FULL_POS]                = ~codeReady_q;
        status_config_vector_reg[`SCV_GRANT_LSB +: 4]          = outIdx_q;
        status_config_vector_reg[`SCV_VECT_LSB +: 8]           = vector_q;
        unique case (busState_q)
            BUS_IDLE: begin
                if (psel && penable) begin
                    pslverr_d = 1'b0;
                    // data access outside the mailbox window goes out on the local bus
                    if (paddr == `OFF_DATA && !addr_q[`ADDR_MBOX_POS]) begin   // see R13 R12
                        busState_d = BUS_LOCAL;
                        lbReq_d    = 1'b1;
                        lbWrite_d  = pwrite;
                        lbAddr_d   = addr_q[LB_AW-1:0];   // see R17
                        lbWdata_d  = pwdata;
                    end else begin
                        busState_d = BUS_DONE;
                        pready_d   = 1'b1;
                        prdata_d   = 32'h0000_0000;
                        case (paddr)
                            `OFF_METER:      prdata_d = 32'(meter_q);   // see R11
                            `OFF_DATA:       prdata_d = mailbox_q;   // see R13
                            `OFF_ADDR:       prdata_d = addr_q;
                            `OFF_SCV:        prdata_d = status_config_vector_reg;   // see R14
                            `OFF_IRQ_STATUS: prdata_d = 32'(irqStat_q);
                            `OFF_IRQ_ENABLE: prdata_d = 32'(irqEn_q);
                            `OFF_IRQ_CLEAR:  prdata_d = 32'h0000_0000;
                            default:         pslverr_d = 1'b1;
                        endcase
                        if (pwrite) begin
                            prdata_d = prdata_q;
                        end
                    end
                end
            end
            BUS_LOCAL: begin
                if (lbAck) begin
                    lbReq_d    = 1'b0;
                    pready_d   = 1'b1;
                    busState_d = BUS_DONE;
                    if (!lbWrite_q) begin
                        prdata_d = lbRdata;
                    end
                end
            end
            BUS_DONE: begin
                busState_d = BUS_IDLE;
                pslverr_d  = 1'b0;
            end
            default: begin
                busState_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busState_q <= BUS_IDLE;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            lbReq_q    <= 1'b0;
            lbWrite_q  <= 1'b0;
            lbAddr_q   <= '0;
            lbWdata_q  <= 32'h0000_0000;
        end else begin
            busState_q <= busState_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            prdata_q   <= prdata_d;
            lbReq_q    <= lbReq_d;
            lbWrite_q  <= lbWrite_d;
            lbAddr_q   <= lbAddr_d;
            lbWdata_q  <= lbWdata_d;
        end
    end

    // =====================================================================
    // registers, code buffer meter and interrupts
    always_comb begin
        // writes land on the edge where the master samples pready, master still holds the request
        doWrite   = busState_q == BUS_DONE && pwrite && !pslverr_q;
        popNow    = busState_q == BUS_DONE && !pwrite && paddr == `OFF_DATA &&
                    addr_q[`ADDR_CODE_POS] && !addr_q[`ADDR_MBOX_POS];
        pushNow   = codeValid && codeReady_q;
        addr_d    = addr_q;
        vector_d  = vector_q;
        pal_d     = pal_q;
        irqEn_d   = irqEn_q;
        irqStat_d = irqStat_q;
        mailbox_d = procWrite ? procData : mailbox_q;   // see R13
        if (doWrite && paddr == `OFF_ADDR) begin
            addr_d = mergeBytes(addr_q, pwdata, pstrb);   // see R12
        end
        if (doWrite && paddr == `OFF_SCV) begin
            if (pstrb[3]) begin
                vector_d = pwdata[`SCV_VECT_LSB +: 8];
            end
            if (pstrb[0]) begin
                pal_d = pwdata[`SCV_PAL_POS];
            end
        end
        if (doWrite && paddr == `OFF_IRQ_ENABLE && pstrb[0]) begin
            irqEn_d = pwdata[3:0];
        end
        if (doWrite && paddr == `OFF_IRQ_CLEAR && pstrb[0]) begin
            irqStat_d = irqStat_q & ~pwdata[3:0];
        end
        // events are or-ed after the clear so a same-cycle event is kept
        irqStat_d[`IRQ_FRAME]   = irqStat_d[`IRQ_FRAME] | frameTick;
        irqStat_d[`IRQ_MBOX]    = irqStat_d[`IRQ_MBOX] | procWrite;
        irqStat_d[`IRQ_FULL]    = irqStat_d[`IRQ_FULL] | (codeValid & ~codeReady_q);
        irqStat_d[`IRQ_OUTDONE] = irqStat_d[`IRQ_OUTDONE] | outDoneEvt;
        irq_d     = |(irqStat_d & irqEn_d);
        // simultaneous push and pop leave the fill level unchanged
        meter_d   = meter_q;   // see R19 R11
        if (pushNow && !popNow) begin
            meter_d = meter_q + MW'(1);
        end else if (popNow && !pushNow && meter_q != '0) begin
            meter_d = meter_q - MW'(1);
        end
        // stall the output bus once the 1 Mbyte buffer is full
        codeReady_d = meter_d < MW'(CODE_WORDS);   // see R10
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_q      <= `RST_ADDR;
            vector_q    <= `RST_VECTOR;
            pal_q       <= 1'b0;
            irqEn_q     <= `RST_IRQ_EN;
            irqStat_q   <= 4'h0;
            irq_q       <= 1'b0;
            mailbox_q   <= 32'h0000_0000;
            meter_q     <= '0;
            codeReady_q <= 1'b0;
        end else begin
            addr_q      <= addr_d;
            vector_q    <= vector_d;
            pal_q       <= pal_d;
            irqEn_q     <= irqEn_d;
            irqStat_q   <= irqStat_d;
            irq_q       <= irq_d;
            mailbox_q   <= mailbox_d;
            meter_q     <= meter_d;
            codeReady_q <= codeReady_d;
        end
    end

    // =====================================================================
    // outputs
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign codeReady   = codeReady_q;
    assign outGrant    = outGrant_q;
    assign captureSel  = captureSel_q;
    assign stageActive = occ_q;
    assign stageStart  = stageStart_q;
    assign lbReq       = lbReq_q;
    assign lbWrite     = lbWrite_q;
    assign lbAddr      = lbAddr_q;
    assign lbWdata     = lbWdata_q;
    assign irq         = irq_q;

    // =====================================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    meter_push_a: assert property (pushNow && !popNow |=> meter_q == $past(meter_q) + MW'(1))   // see R19
        else $error("meter did not count a pushed word");
    meter_pop_a: assert property (popNow && !pushNow && meter_q != '0 |=> meter_q == $past(meter_q) - MW'(1))   // see R19
        else $error("meter did not count a popped word");
    buffer_full_a: assert property (meter_q >= MW'(CODE_WORDS) |-> !codeReady_q)   // see R10
        else $error("code buffer accepts words while full");
    stage_shift_a: assert property (frameTick |=> occ_q == {$past(occ_q[3:0]), $past(encodeRun)})   // see R1
        else $error("stages did not advance on frame tick");
    stage_hold_a: assert property (!frameTick |=> $stable(occ_q) && stageStart_q == 5'h00)   // see R2
        else $error("stages moved without a frame tick");
    slice_total_a: assert property (frameTick && lineCount_q == lines |-> sliceIdx_q == slices)   // see R3
        else $error("frame did not end on the last slice");
    out_order_a: assert property (outBusy_q && sliceDone && !frameTick && outIdx_q != slices - 4'h1
                                  |=> outIdx_q == $past(outIdx_q) + 4'h1 && outGrant_q[outIdx_q])   // see R9
        else $error("output grant skipped a processor");
    local_wait_a: assert property (lbReq_q && !lbAck |=> lbReq_q && $stable(lbAddr_q) && !pready_q)   // see R13
        else $error("local request dropped before acknowledge");
    ready_pulse_a: assert property (pready_q |=> !pready_q ##1 !pready_q)
        else $error("pready held longer than one cycle");
    irq_level_a: assert property (irq_q == |(irqStat_q & irqEn_q))
        else $error("interrupt output disagrees with status");
    scv_read_a: assert property (busState_q == BUS_IDLE && psel && penable && !pwrite && paddr == `OFF_SCV
                                 |=> prdata_q[`SCV_STAGE_LSB +: 5] == $past(occ_q) && pready_q)   // see R14
        else $error("status register read wrong stage bits");
endmodule

/* verilog/host_port_defines.svh */
// register offsets, field positions, reset values and stage numbers of the encoder host port
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// =====================================================================
// register byte offsets
`define OFF_METER        8'h00
`define OFF_DATA         8'h04
`define OFF_ADDR         8'h08
`define OFF_SCV          8'h0c
`define OFF_IRQ_STATUS   8'h10
`define OFF_IRQ_ENABLE   8'h14
`define OFF_IRQ_CLEAR    8'h18

// =====================================================================
// address register fields
`define ADDR_CODE_POS    19
`define ADDR_MBOX_POS    20

// status_config_vector_reg fields
`define SCV_RUN_POS      0
`define SCV_STAGE_LSB    1
`define SCV_PAL_POS      6
`define SCV_FULL_POS     7
`define SCV_GRANT_LSB    8
`define SCV_VECT_LSB     24

// interrupt bits
`define IRQ_FRAME        0
`define IRQ_MBOX         1
`define IRQ_FULL         2
`define IRQ_OUTDONE      3

// =====================================================================
// reset values
`define RST_ADDR         32'h0000_0000
`define RST_VECTOR       8'h00
`define RST_IRQ_EN       4'h0

// pipeline stage positions
`define STAGE_CAPTURE    0
`define STAGE_PREPROC    1
`define STAGE_MOTION     2
`define STAGE_ENCODE     3
`define STAGE_OUTPUT     4

`endif

/* verilog/host_port_pkg.sv */
// types shared by the encoder host port
package host_port_pkg;
    typedef enum logic [1:0] {BUS_IDLE, BUS_LOCAL, BUS_DONE} busState_type;
    typedef logic [4:0] stageVec_type;
    typedef logic [3:0] irqVec_type;
endpackage
